// >>> verilog/fan_ramp_defs.svh
// register map, reset values and timing counts of the fan duty ramp controller
// assumes a 250 MHz reference clock and word-indexed AXI4-Lite decoding
`ifndef FAN_RAMP_DEFS_SVH
`define FAN_RAMP_DEFS_SVH

// word indices; byte address is four times the index
`define IDX_RAMP_CTRL 10'h023
`define IDX_MODE_CONFIG 10'h040
`define IDX_DIRECT_DUTY 10'h041
`define IDX_THERMAL_BASE 10'h042
`define IDX_TACH_TARGET 10'h043
`define IDX_STATUS 10'h044

`define RST_RAMP_CTRL 8'h52
`define RST_MODE_CONFIG 7'h11
`define RST_DIRECT_DUTY 8'h00
`define RST_THERMAL_BASE 13'h0c55
`define RST_TACH_TARGET 16'h1000

`define TACH_DEADBAND 17'h0000a
`define LOW_TEMP_STEP_C 8'h04
`define GAIN_MAX_CODE 3'h4
`define DUTY_FULL 8'hff

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define REF_CLK_MHZ 250
`define BASE_TICK_US 125000
`define BASE_TICK_CYCLES (`BASE_TICK_US * `REF_CLK_MHZ)
`define SLOWEST_RATE_TICKS 8'h80

`endif

// >>> verilog/fan_ramp_pkg.sv
// types shared by the fan duty ramp controller and its bench
// assumes the layout constants in fan_ramp_defs.svh
package fan_ramp_pkg;

  typedef struct packed {
    logic gradual_change_enable;
    logic [1:0] max_increment_sel;
    logic [2:0] update_rate_sel;
    logic [1:0] deadband_sel;
  } ramp_ctrl_t;

  typedef enum logic [2:0] {
    thermal_loop = 3'b001,
    speed_regulation_mode = 3'b010,
    direct_duty_mode = 3'b100
  } loop_mode_t;

  typedef struct packed {
    logic [2:0] remote_gain_sel;
    logic unused_bit;
    logic [2:0] mode;
  } mode_config_t;

  typedef struct packed {
    logic [4:0] low_temp_code;
    logic [7:0] low_duty;
  } thermal_base_t;

  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

endpackage

// >>> verilog/fan_duty_ramp_control.sv
// fan duty ramp controller: moves the fan duty toward its target per loop mode
// assumes register access over AXI4-Lite on ref_clk; temperature and tach inputs come from ref_clk logic
`timescale 1ns/100ps
`include "fan_ramp_defs.svh"

// Summary of operation
// RQ1: thermal target rises by the selected remote gain per degree above low temperature
// RQ2: with gradual change on, steps are capped by selected size; off, duty jumps
// RQ3: thermal loop updates duty at the rate chosen by the three-bit rate field
// RQ4: in direct duty mode the ramp register is ignored entirely
// RQ5: the ramp step size governs convergence in both thermal and speed-regulation loops
// RQ6: speed-regulation mode treats gradual change as always enabled
// RQ7: speed-regulation mode moves in selected steps, clamped at 0x00 and 0xff, never one jump
// RQ8: deadband codes select 1/256 to 4/256; code 10 is the reset value
// RQ9: thermal loop holds duty while remaining adjustment is within the deadband
// RQ10: when remaining adjustment is below the step, apply exactly the remainder
// RQ11: speed-regulation stops when tach error magnitude is at most 0x000a
module fan_duty_ramp_control #(
  parameter int unsigned BASE_TICK_CYCLES = `BASE_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fan_ramp_pkg::axil_req_t axil_req,
  output fan_ramp_pkg::axil_rsp_t axil_rsp,
  input wire logic signed [7:0] remote_temp,
  input wire logic [15:0] tach_count,
  input wire logic tach_valid,
  output logic [7:0] duty_fraction
);
  import fan_ramp_pkg::*;

  ramp_ctrl_t duty_ramp_control;
  mode_config_t mode_config;
  logic [7:0] direct_duty;
  thermal_base_t thermal_base;
  logic [15:0] tach_target;

  logic aw_held;
  logic w_held;
  logic [9:0] aw_index;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_value;
  logic rd_hit;
  logic aw_ready;
  logic w_ready;
  logic b_valid;
  logic [1:0] b_resp;
  logic ar_ready;
  logic r_valid;
  logic [31:0] r_data;
  logic [1:0] r_resp;

  logic [31:0] base_cnt;
  logic base_tick;
  logic [7:0] slow_cnt;
  logic [7:0] rate_period;
  logic rate_tick;

  logic [7:0] target_duty;
  logic [7:0] next_duty;
  logic [5:0] gain;
  logic signed [8:0] excess;
  logic [12:0] raised;
  logic signed [8:0] gap;
  logic [7:0] gap_mag;
  logic [7:0] step_size;
  logic [7:0] deadband;
  logic signed [16:0] tach_err;
  logic [16:0] tach_mag;
  logic [8:0] up_sum;
  logic loop_busy;

  // write address and write data are taken independently, in either order
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      aw_index <= 10'h000;
      aw_ready <= 1'b1;
    end
    else if (axil_req.awvalid && aw_ready)
    begin
      aw_held <= 1'b1;
      aw_index <= axil_req.awaddr[11:2];
      aw_ready <= 1'b0;
    end
    else if (do_write)
      aw_held <= 1'b0;
    else if (b_valid && axil_req.bready)
      aw_ready <= 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_ready <= 1'b1;
    end
    else if (axil_req.wvalid && w_ready)
    begin
      w_held <= 1'b1;
      w_data <= axil_req.wdata;
      w_strb <= axil_req.wstrb;
      w_ready <= 1'b0;
    end
    else if (do_write)
      w_held <= 1'b0;
    else if (b_valid && axil_req.bready)
      w_ready <= 1'b1;
  end

  assign do_write = aw_held && w_held && !b_valid;
  assign wr_hit = (aw_index == `IDX_RAMP_CTRL) || (aw_index == `IDX_MODE_CONFIG) ||
                  (aw_index == `IDX_DIRECT_DUTY) || (aw_index == `IDX_THERMAL_BASE) ||
                  (aw_index == `IDX_TACH_TARGET);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      b_valid <= 1'b0;
      b_resp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      b_valid <= 1'b1;
      b_resp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (axil_req.bready)
      b_valid <= 1'b0;
  end

  // register stores; byte lanes honoured, lane 1 only matters for wide fields
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      duty_ramp_control <= `RST_RAMP_CTRL; // RQ8
      mode_config <= `RST_MODE_CONFIG;
      direct_duty <= `RST_DIRECT_DUTY;
      thermal_base <= `RST_THERMAL_BASE;
      tach_target <= `RST_TACH_TARGET;
    end
    else if (do_write)
    begin
      case (aw_index)
        `IDX_RAMP_CTRL:
          if (w_strb[0])
            duty_ramp_control <= w_data[7:0];
        `IDX_MODE_CONFIG:
          if (w_strb[0])
            mode_config <= w_data[6:0];
        `IDX_DIRECT_DUTY:
          if (w_strb[0])
            direct_duty <= w_data[7:0];
        `IDX_THERMAL_BASE:
        begin
          if (w_strb[0])
            thermal_base.low_duty <= w_data[7:0];
          if (w_strb[1])
            thermal_base.low_temp_code <= w_data[12:8];
        end
        `IDX_TACH_TARGET:
        begin
          if (w_strb[0])
            tach_target[7:0] <= w_data[7:0];
          if (w_strb[1])
            tach_target[15:8] <= w_data[15:8];
        end
        default:
          tach_target <= tach_target;
      endcase
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_value = 32'h0000_0000;
    case (axil_req.araddr[11:2])
      `IDX_RAMP_CTRL:
        rd_value = {24'h000000, duty_ramp_control};
      `IDX_MODE_CONFIG:
        rd_value = {25'h0000000, mode_config};
      `IDX_DIRECT_DUTY:
        rd_value = {24'h000000, direct_duty};
      `IDX_THERMAL_BASE:
        rd_value = {19'h00000, thermal_base};
      `IDX_TACH_TARGET:
        rd_value = {16'h0000, tach_target};
      `IDX_STATUS:
        rd_value = {15'h0000, loop_busy, target_duty, duty_fraction};
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ar_ready <= 1'b1;
      r_valid <= 1'b0;
      r_data <= 32'h0000_0000;
      r_resp <= `RESP_OKAY;
    end
    else if (axil_req.arvalid && ar_ready)
    begin
      ar_ready <= 1'b0;
      r_valid <= 1'b1;
      r_data <= rd_value;
      r_resp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (r_valid && axil_req.rready)
    begin
      r_valid <= 1'b0;
      ar_ready <= 1'b1;
    end
  end

  // each response field has its own flop; the port struct only gathers them
  assign axil_rsp = '{awready: aw_ready, wready: w_ready, bvalid: b_valid, bresp: b_resp, arready: ar_ready,
                      rvalid: r_valid, rdata: r_data, rresp: r_resp};

  // 8 Hz base tick, then a power-of-two divider: code 7 every tick, code 0 every 128
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      base_cnt <= 32'h0000_0000;
    else if (base_tick)
      base_cnt <= 32'h0000_0000;
    else
      base_cnt <= base_cnt + 32'h0000_0001;
  end

  assign base_tick = (base_cnt == BASE_TICK_CYCLES - 1);
  assign rate_period = `SLOWEST_RATE_TICKS >> duty_ramp_control.update_rate_sel;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      slow_cnt <= 8'h00;
    else if (rate_tick)
      slow_cnt <= 8'h00;
    else if (base_tick)
      slow_cnt <= slow_cnt + 8'h01;
  end

  assign rate_tick = base_tick && (slow_cnt >= rate_period - 8'h01); // RQ3

  // thermal target: base duty plus gain per degree above the low temperature
  always_comb
  begin
    if (mode_config.remote_gain_sel > `GAIN_MAX_CODE)
      gain = 6'h01;
    else
      gain = 6'h20 >> mode_config.remote_gain_sel;
    excess = 9'(remote_temp) - 9'(signed'({1'b0, thermal_base.low_temp_code} * `LOW_TEMP_STEP_C));
    if (excess <= 9'sh000)
      raised = {5'h00, thermal_base.low_duty};
    else
      raised = 13'(excess[7:0]) * 13'(gain) + {5'h00, thermal_base.low_duty}; // RQ1
    target_duty = (raised > {5'h00, `DUTY_FULL}) ? `DUTY_FULL : raised[7:0];
  end

  assign step_size = 8'h01 << duty_ramp_control.max_increment_sel; // RQ5
  assign deadband = {6'h00, duty_ramp_control.deadband_sel} + 8'h01; // RQ8
  assign gap = 9'(target_duty) - 9'(duty_fraction);
  assign gap_mag = gap[8] ? 8'(-gap) : gap[7:0];
  assign tach_err = 17'(tach_count) - 17'(tach_target);
  assign tach_mag = tach_err[16] ? 17'(-tach_err) : tach_err;
  assign up_sum = {1'b0, duty_fraction} + {1'b0, step_size};

  always_comb
  begin
    next_duty = duty_fraction;
    loop_busy = 1'b0;
    case (mode_config.mode)
      thermal_loop:
      begin
        loop_busy = gap_mag > deadband;
        if (rate_tick && gap_mag > deadband) // RQ9
        begin
          if (!duty_ramp_control.gradual_change_enable)
            next_duty = target_duty; // RQ2
          else if (gap_mag < step_size)
            next_duty = target_duty; // RQ10
          else if (gap[8])
            next_duty = duty_fraction - step_size; // RQ2
          else
            next_duty = duty_fraction + step_size;
        end
      end
      speed_regulation_mode:
      begin
        loop_busy = tach_mag > `TACH_DEADBAND;
        // slow fan shows a larger tach count, so duty rises; enable bit not consulted
        if (tach_valid && tach_mag > `TACH_DEADBAND) // RQ11
        begin
          if (!tach_err[16])
            next_duty = up_sum[8] ? `DUTY_FULL : up_sum[7:0]; // RQ7
          else if (duty_fraction < step_size)
            next_duty = 8'h00;
          else
            next_duty = duty_fraction - step_size; // RQ6
        end
      end
      direct_duty_mode:
        next_duty = direct_duty; // RQ4
      default:
        next_duty = duty_fraction;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      duty_fraction <= 8'h00;
    else
      duty_fraction <= next_duty;
  end

endmodule

// >>> bench/fan_duty_ramp_control_sva.sv
// checker for the fan duty ramp controller, bound to its top module
// assumes writes offer address and data together, as the bench does
`timescale 1ns/100ps
module fan_duty_ramp_sva #(
  parameter int unsigned BASE_TICK_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire fan_ramp_pkg::axil_req_t axil_req,
  input wire fan_ramp_pkg::axil_rsp_t axil_rsp,
  input wire logic signed [7:0] remote_temp,
  input wire logic [15:0] tach_count,
  input wire logic tach_valid,
  input wire logic [7:0] duty_fraction
);
  import fan_ramp_pkg::*;
  logic [2:0] mode;
  ramp_ctrl_t ctrl;
  logic [15:0] tgt;
  logic [7:0] prev;
  logic [7:0] stp;
  int quiet;
  int since;
  int gap;
  wire take = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  // shadows lead the design by one edge; awready is low over that gap
  wire spd = mode == 3'b010 && axil_rsp.awready;
  wire thm = mode == 3'b001 && axil_rsp.awready;
  wire [16:0] hi = {1'b0, tgt} + 17'h0000a;
  wire [16:0] lo = {1'b0, tach_count} + 17'h0000a;
  assign stp = 8'h01 << ctrl.max_increment_sel;
  assign gap = BASE_TICK_CYCLES << (3'h7 - ctrl.update_rate_sel);
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      mode <= 3'b001;
      ctrl <= 8'h52;
      tgt <= 16'h1000;
    end
    else if (take)
    begin
      if (axil_req.awaddr[11:2] == 10'h040) mode <= axil_req.wdata[2:0];
      if (axil_req.awaddr[11:2] == 10'h023) ctrl <= axil_req.wdata[7:0];
      if (axil_req.awaddr[11:2] == 10'h043) tgt <= axil_req.wdata[15:0];
    end
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      prev <= 8'h00;
      since <= 0;
      quiet <= 0;
    end
    else
    begin
      prev <= duty_fraction;
      since <= (duty_fraction != prev) ? 0 : since + 1;
      quiet <= take ? 0 : (quiet < 99999 ? quiet + 1 : quiet);
    end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_SPEED_HOLD: assert property (spd && !tach_valid |=> $stable(duty_fraction))
    else $error("speed duty moved without tach pulse");
  AST_SPEED_UP: assert property (spd && tach_valid && {1'b0, tach_count} > hi && duty_fraction <= 8'hff - stp
    |=> duty_fraction == $past(duty_fraction) + $past(stp)) else $error("speed duty did not rise by one step");
  AST_SPEED_DOWN: assert property (spd && tach_valid && lo < {1'b0, tgt} && duty_fraction >= stp
    |=> duty_fraction == $past(duty_fraction) - $past(stp)) else $error("speed duty did not fall by one step");
  AST_SPEED_DEADBAND: assert property (spd && tach_valid && {1'b0, tach_count} <= hi && lo >= {1'b0, tgt}
    |=> $stable(duty_fraction)) else $error("speed duty moved inside tach deadband");
  AST_THERM_STEP: assert property (thm && ctrl.gradual_change_enable
    |=> (duty_fraction - $past(duty_fraction)) <= $past(stp) || ($past(duty_fraction) - duty_fraction) <= $past(stp))
    else $error("thermal duty moved more than one step");
  AST_THERM_PACE: assert property (thm && quiet > 2 * gap && $changed(duty_fraction) |-> since >= gap - 1)
    else $error("thermal duty updated faster than rate");
  AST_DIRECT_IGNORES: assert property ((mode == 3'b100 && axil_rsp.awready) [*3] |-> $stable(duty_fraction))
    else $error("direct duty moved without a write");
  AST_FREEZE_OTHER: assert property (!(mode inside {3'b001, 3'b010, 3'b100}) && axil_rsp.awready
    |=> $stable(duty_fraction)) else $error("duty moved in unused mode");
endmodule
bind fan_duty_ramp_control fan_duty_ramp_sva #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) chk (.ref_clk(ref_clk),
  .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp), .remote_temp(remote_temp), .tach_count(tach_count),
  .tach_valid(tach_valid), .duty_fraction(duty_fraction));

// >>> bench/tb_fan_duty_ramp_control.sv
// self-checking bench of the fan duty ramp controller
// assumes a short base tick so every rate code fits in the run
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_fan_duty_ramp_control;
  import fan_ramp_pkg::*;
  localparam int B = 8;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tach_valid = 1'b0;
  logic signed [7:0] remote_temp = 8'sd48;
  logic [15:0] tach_count = 16'h1000;
  logic [7:0] duty_fraction;
  logic [7:0] e;
  axil_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  axil_rsp_t rsp;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  int r;
  logic [15:0] tc[5] = '{16'h1100, 16'h100a, 16'h0ff6, 16'h0ff5, 16'h100b};
  logic [7:0] te[5] = '{8'h44, 8'h44, 8'h44, 8'h3c, 8'h44};
  fan_duty_ramp_control #(.BASE_TICK_CYCLES(B)) uut (.ref_clk(ref_clk), .rst(rst), .axil_req(req),
    .axil_rsp(rsp), .remote_temp(remote_temp), .tach_count(tach_count), .tach_valid(tach_valid),
    .duty_fraction(duty_fraction));
  initial forever #2 ref_clk = ~ref_clk;
  task automatic results();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
    req.awaddr <= {i, 2'b00};
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    `CHK(rsp.bresp, er)
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
    req.araddr <= {i, 2'b00};
    req.arvalid <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    `CHK(rsp.rdata, d)
    `CHK(rsp.rresp, er)
  endtask
  task automatic wd(input logic [7:0] x, input int lim);
    repeat (lim)
    begin
      @(posedge ref_clk);
      if (duty_fraction === x) break;
    end
    `CHK(duty_fraction, x)
  endtask
  task automatic wc(output int k);
    logic [7:0] v;
    v = duty_fraction;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (duty_fraction === v && k < 5000);
  endtask
  task automatic tp(input logic [15:0] c);
    tach_count <= c;
    tach_valid <= 1'b1;
    @(posedge ref_clk);
    tach_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(10'h023, 32'h52, 2'b00);
    rd(10'h040, 32'h11, 2'b00);
    rd(10'h3ff, 32'h0, 2'b10);
    wr(10'h3ff, 32'h5a, 2'b10);
    wd(8'h55, 200);
    wr(10'h023, 32'h1c, 2'b00);
    remote_temp <= 8'sd50;
    for (r = 0; r < 5; r++)
    begin
      wr(10'h040, 32'h01 | (r << 4), 2'b00);
      wd(8'(8'h55 + (64 >> r)), 60);
    end
    remote_temp <= 8'sd48;
    wr(10'h040, 32'h71, 2'b00);
    wd(8'h55, 60);
    wr(10'h023, 32'hdc, 2'b00);
    remote_temp <= 8'sd70;
    wc(n);
    `CHK(duty_fraction, 8'h59)
    wd(8'h6b, 100);
    wr(10'h023, 32'hdf, 2'b00);
    remote_temp <= 8'sd74;
    repeat (40) @(posedge ref_clk);
    `CHK(duty_fraction, 8'h6b)
    rd(10'h044, 32'h0000_6f6b, 2'b00);
    remote_temp <= 8'sd75;
    repeat (40) @(posedge ref_clk);
    `CHK(duty_fraction, 8'h6f)
    remote_temp <= 8'sd100;
    for (r = 0; r < 8; r++)
    begin
      wr(10'h023, 32'h80 | (r << 2), 2'b00);
      wc(n);
      wc(n);
      `CHK(n, B << (7 - r))
    end
    wr(10'h041, 32'h3c, 2'b00);
    wr(10'h040, 32'h74, 2'b00);
    wd(8'h3c, 10);
    wr(10'h023, 32'hff, 2'b00);
    remote_temp <= -8'sd20;
    repeat (64) @(posedge ref_clk);
    `CHK(duty_fraction, 8'h3c)
    wr(10'h040, 32'h70, 2'b00);
    wr(10'h023, 32'h60, 2'b00);
    wr(10'h040, 32'h72, 2'b00);
    for (r = 0; r < 5; r++)
    begin
      tp(tc[r]);
      `CHK(duty_fraction, te[r])
    end
    e = 8'h44;
    for (r = 0; r < 4; r++)
    begin
      wr(10'h023, r << 5, 2'b00);
      tp(16'h2000);
      e = e + (8'h01 << r);
      `CHK(duty_fraction, e)
    end
    rd(10'h044, 32'h0001_5553, 2'b00);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(duty_fraction, 8'h00)
    rd(10'h023, 32'h52, 2'b00);
    results();
  end
  initial
  begin
    #200000;
    bad_count++;
    results();
  end
endmodule
